// file: src/cmpd_pkg.sv
// Package of constants and types for the control mode pin decoder.
package cmpd_pkg;

    // ****************************************************************
    // Pin level encoding
    // ****************************************************************

    // Sensed level of one three-level configuration pin.
    typedef enum logic [1:0] {
        CMPD_LVL_LOW   = 2'b00,
        CMPD_LVL_HIGH  = 2'b01,
        CMPD_LVL_FLOAT = 2'b10
    } cmpd_level_t;

    // Pin index in the raw sense vectors.
    localparam int CMPD_PIN_SWING = 0;
    localparam int CMPD_PIN_EDGE  = 1;
    localparam int CMPD_PIN_CAL   = 2;
    localparam int CMPD_PIN_MODE  = 3;
    localparam int CMPD_NUM_PINS  = 4;

    // ****************************************************************
    // Register map
    // ****************************************************************

    localparam logic [11:0] CMPD_OFS_STATUS = 12'h000;
    localparam logic [11:0] CMPD_OFS_CHANGE = 12'h004;
    localparam logic [11:0] CMPD_OFS_PINS   = 12'h008;

    // Status register field positions.
    localparam int CMPD_ST_EXTENDED = 0;
    localparam int CMPD_ST_RANGE    = 1;
    localparam int CMPD_ST_SWING    = 2;
    localparam int CMPD_ST_EDGE     = 3;
    localparam int CMPD_ST_DDR      = 4;
    localparam int CMPD_ST_CALIBRATION_DELAY_SELECT   = 5;
    localparam int CMPD_ST_DES      = 6;

    // Change register field positions, write one to clear.
    localparam int CMPD_CH_CONFIG = 0;
    localparam int CMPD_CH_FAULT  = 1;

    // Reset values.
    localparam logic [6:0]  CMPD_RST_CONFIG = 7'h00;
    localparam logic [31:0] CMPD_RST_RDATA  = 32'h0000_0000;

endpackage : cmpd_pkg

// file: src/cmpd_pin_sync.sv
// Three-stage synchroniser with agreement filter for raw pin senses.
`timescale 1ns/1ps

module cmpd_pin_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Raw asynchronous senses and settled result
    input  wire logic [WIDTH-1:0] raw,
    output logic      [WIDTH-1:0] settled
);

    // ****************************************************************
    // Per-bit synchroniser
    // ****************************************************************

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic stage1;
            logic stage2;
            logic stage3;
            logic held;
            logic next_held;

            // Only stages two and three are compared; stage one is read
            // by stage two alone so metastability cannot leak out.
            always_comb begin
                next_held = (stage2 == stage3) ? stage3 : held;
            end

            // Registers of the chain and the accepted value.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stage1 <= 1'b0;
                    stage2 <= 1'b0;
                    stage3 <= 1'b0;
                    held   <= 1'b0;
                end else begin
                    stage1 <= raw[i];
                    stage2 <= stage1;
                    stage3 <= stage2;
                    held   <= next_held;
                end
            end

            assign settled[i] = held;
        end
    endgenerate

endmodule : cmpd_pin_sync

// file: src/cmpd_decoder.sv
// Three-level configuration pin decoder with APB status registers.
//
// What this block does
// - Mode pin high or low: pin-controlled mode, serial interface idle.
// - Pin-controlled mode: mode pin low 650 mV range, high 870 mV.
// - Mode pin floating selects extended control mode.
// - Swing pin must be driven; low gives 0.50 V, high 0.70 V swing.
// - Edge pin high: data changes on positive clock edge, low negative.
// - Edge pin floating: double data rate output clock, edge ignored.
// - Calibration pin high or low selects high or low delay.
// - Calibration pin floating: low delay plus dual edge sampling.
// - Extended mode: pins become serial clock, data and select.
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps

module cmpd_decoder (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Pin senses: high comparator and floating detector per pin
    input  wire logic [3:0]  pin_is_high,
    input  wire logic [3:0]  pin_is_float,
    // Decoded configuration
    output logic             extended_mode,
    output logic             input_range_870,
    output logic             output_swing_700,
    output logic             output_edge_select,
    output logic             output_data_clock_ddr,
    output logic             calibration_delay_select,
    output logic             dual_edge_sampling,
    // Serial interface pins routed out in extended mode
    output logic             serial_interface_clock,
    output logic             serial_interface_data,
    output logic             serial_interface_select,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr
);

    // ****************************************************************
    // Pin sensing
    // ****************************************************************

    logic [7:0] settled;
    cmpd_pin_sync #(
        .WIDTH   (8)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .raw     ({pin_is_float, pin_is_high}),
        .settled (settled)
    );

    // Floating detection wins over the high comparator.
    cmpd_pkg::cmpd_level_t lvl [cmpd_pkg::CMPD_NUM_PINS];
    always_comb begin
        for (int p = 0; p < cmpd_pkg::CMPD_NUM_PINS; p++) begin
            if (settled[4 + p]) begin
                lvl[p] = cmpd_pkg::CMPD_LVL_FLOAT;
            end else if (settled[p]) begin
                lvl[p] = cmpd_pkg::CMPD_LVL_HIGH;
            end else begin
                lvl[p] = cmpd_pkg::CMPD_LVL_LOW;
            end
        end
    end

    // ****************************************************************
    // Decode
    // ****************************************************************

    logic next_extended;
    logic next_range;
    logic next_swing;
    logic next_edge;
    logic next_ddr;
    logic next_calibration_delay_select;
    logic next_des;
    logic next_sclk;
    logic next_serial_interface_data;
    logic next_ssel;
    logic swing_fault;

    // Pin-controlled settings are held while in extended mode, so toggles
    // on the pins, now serial clock, data and select, cannot move them there.
    always_comb begin
        next_extended = extended_mode;
        next_range    = input_range_870;
        next_swing    = output_swing_700;
        next_edge     = output_edge_select;
        next_ddr      = output_data_clock_ddr;
        next_calibration_delay_select   = calibration_delay_select;
        next_des      = dual_edge_sampling;
        next_sclk     = 1'b0;
        next_serial_interface_data    = 1'b0;
        next_ssel     = 1'b1;  // Select is active low, idle high.
        swing_fault   = 1'b0;
        case (lvl[cmpd_pkg::CMPD_PIN_MODE])
            cmpd_pkg::CMPD_LVL_FLOAT: begin
                next_extended = 1'b1;
                next_sclk  = settled[cmpd_pkg::CMPD_PIN_SWING];
                next_serial_interface_data = settled[cmpd_pkg::CMPD_PIN_EDGE];
                next_ssel  = settled[cmpd_pkg::CMPD_PIN_CAL];
            end
            cmpd_pkg::CMPD_LVL_LOW, cmpd_pkg::CMPD_LVL_HIGH: begin
                next_extended = 1'b0;
                next_range = (lvl[cmpd_pkg::CMPD_PIN_MODE]
                              == cmpd_pkg::CMPD_LVL_HIGH);
                next_swing  = settled[cmpd_pkg::CMPD_PIN_SWING];
                swing_fault = (lvl[cmpd_pkg::CMPD_PIN_SWING]
                               == cmpd_pkg::CMPD_LVL_FLOAT);
                next_ddr  = (lvl[cmpd_pkg::CMPD_PIN_EDGE]
                             == cmpd_pkg::CMPD_LVL_FLOAT);
                next_edge = (lvl[cmpd_pkg::CMPD_PIN_EDGE]
                             == cmpd_pkg::CMPD_LVL_HIGH);
                next_calibration_delay_select = (lvl[cmpd_pkg::CMPD_PIN_CAL]
                               == cmpd_pkg::CMPD_LVL_HIGH);
                next_des    = (lvl[cmpd_pkg::CMPD_PIN_CAL]
                               == cmpd_pkg::CMPD_LVL_FLOAT);
            end
            default: begin
                next_extended = extended_mode;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            extended_mode            <= cmpd_pkg::CMPD_RST_CONFIG[0];
            input_range_870          <= cmpd_pkg::CMPD_RST_CONFIG[1];
            output_swing_700         <= cmpd_pkg::CMPD_RST_CONFIG[2];
            output_edge_select       <= cmpd_pkg::CMPD_RST_CONFIG[3];
            output_data_clock_ddr    <= cmpd_pkg::CMPD_RST_CONFIG[4];
            calibration_delay_select <= cmpd_pkg::CMPD_RST_CONFIG[5];
            dual_edge_sampling       <= cmpd_pkg::CMPD_RST_CONFIG[6];
            serial_interface_clock   <= 1'b0;
            serial_interface_data    <= 1'b0;
            serial_interface_select  <= 1'b1;
        end else begin
            extended_mode            <= next_extended;
            input_range_870          <= next_range;
            output_swing_700         <= next_swing;
            output_edge_select       <= next_edge;
            output_data_clock_ddr    <= next_ddr;
            calibration_delay_select <= next_calibration_delay_select;
            dual_edge_sampling       <= next_des;
            serial_interface_clock   <= next_sclk;
            serial_interface_data    <= next_serial_interface_data;
            serial_interface_select  <= next_ssel;
        end
    end

    // ****************************************************************
    // APB registers
    // ****************************************************************

    logic [6:0]  config_now;
    logic [6:0]  config_next;
    logic        chg_config;
    logic        chg_fault;
    logic        next_chg_config;
    logic        next_chg_fault;
    logic        next_pready;
    logic        next_pslverr;
    logic [31:0] next_prdata;
    logic        wr_done;

    assign config_now  = {dual_edge_sampling, calibration_delay_select,
                          output_data_clock_ddr, output_edge_select,
                          output_swing_700, input_range_870,
                          extended_mode};
    assign config_next = {next_des, next_calibration_delay_select, next_ddr, next_edge,
                          next_swing, next_range, next_extended};
    assign wr_done     = psel & penable & pready & pwrite;

    // Sticky flags: a new event in the clearing cycle wins over the
    // clear so that no change slips by unseen.
    always_comb begin
        next_chg_config = chg_config;
        next_chg_fault  = chg_fault;
        if (wr_done && paddr == cmpd_pkg::CMPD_OFS_CHANGE) begin
            if (pwdata[cmpd_pkg::CMPD_CH_CONFIG]) begin
                next_chg_config = 1'b0;
            end
            if (pwdata[cmpd_pkg::CMPD_CH_FAULT]) begin
                next_chg_fault = 1'b0;
            end
        end
        if (config_next != config_now) begin
            next_chg_config = 1'b1;
        end
        if (swing_fault) begin
            next_chg_fault = 1'b1;
        end
    end

    // Answer is prepared in the setup cycle, so every access ends at
    // its first access edge; reads see state of the setup cycle.
    always_comb begin
        next_pready  = psel & ~penable;
        next_pslverr = 1'b0;
        next_prdata  = 32'h0000_0000;
        if (psel && !penable) begin
            case (paddr)
                cmpd_pkg::CMPD_OFS_STATUS: begin
                    next_prdata[6:0] = config_now;
                end
                cmpd_pkg::CMPD_OFS_CHANGE: begin
                    next_prdata[cmpd_pkg::CMPD_CH_CONFIG] = chg_config;
                    next_prdata[cmpd_pkg::CMPD_CH_FAULT]  = chg_fault;
                end
                cmpd_pkg::CMPD_OFS_PINS: begin
                    next_prdata[7:0] = settled;
                end
                default: begin
                    next_pslverr = 1'b1;
                end
            endcase
        end
    end

    // Bus and flag registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            prdata     <= cmpd_pkg::CMPD_RST_RDATA;
            chg_config <= 1'b0;
            chg_fault  <= 1'b0;
        end else begin
            pready     <= next_pready;
            pslverr    <= next_pslverr;
            prdata     <= next_prdata;
            chg_config <= next_chg_config;
            chg_fault  <= next_chg_fault;
        end
    end

endmodule : cmpd_decoder

// file: tb/cmpd_pin_strap.sv
// Strap and host model driving the three-level configuration pins.
`timescale 1ns/1ps
module cmpd_pin_strap (
    // Clock for floating-pin noise
    input  wire logic       pclk,
    // Requested level per pin, two bits each
    input  wire logic [7:0] lvl,
    // Senses seen by the decoder
    output logic      [3:0] pin_is_high,
    output logic      [3:0] pin_is_float
);
    logic noise = 1'b0;
    // A floating pin has no trustworthy high sense, so it toggles.
    always @(posedge pclk) noise <= ~noise;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_is_float[i] = lvl[2*i+:2] == cmpd_pkg::CMPD_LVL_FLOAT;
            pin_is_high[i]  = pin_is_float[i] ? noise : lvl[2*i];
        end
    end
endmodule : cmpd_pin_strap

// file: tb/cmpd_decoder_sva.sv
// Concurrent checks on the pin decoder ports.
`timescale 1ns/1ps
module cmpd_decoder_sva (
    // Clock, reset and pin senses
    input wire logic        pclk, presetn,
    input wire logic [3:0]  pin_is_high, pin_is_float,
    // Decoded settings and serial pins
    input wire logic        extended_mode, input_range_870,
    input wire logic        output_swing_700, output_edge_select,
    input wire logic        output_data_clock_ddr, dual_edge_sampling,
    input wire logic        calibration_delay_select,
    input wire logic        serial_interface_clock, serial_interface_data,
    input wire logic        serial_interface_select,
    // APB
    input wire logic        psel, penable, pready, pslverr,
    input wire logic [11:0] paddr
);
    logic [7:0] lv_q;
    logic [3:0] calm;
    wire  [7:0] lv = {pin_is_float, pin_is_high & ~pin_is_float};
    // A pin change that the counter has not yet seen also breaks the calm.
    wire        s = calm > 4'h5 && lv == lv_q;
    wire        m = s && !pin_is_float[3];
    // Addresses outside the three mapped words must be refused.
    wire        bad = !(paddr inside {cmpd_pkg::CMPD_OFS_STATUS,
                        cmpd_pkg::CMPD_OFS_CHANGE, cmpd_pkg::CMPD_OFS_PINS});
    wire  [2:0] ser = {serial_interface_clock, serial_interface_data,
                       serial_interface_select};
    wire  [5:0] cfg = {input_range_870, output_swing_700, output_edge_select,
                       output_data_clock_ddr, calibration_delay_select,
                       dual_edge_sampling};
    // Quiet-cycle count, so checks wait out the synchroniser latency.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lv_q <= 8'h00;
            calm <= 4'h0;
        end else begin
            lv_q <= lv;
            calm <= (lv != lv_q) ? 4'h0 : calm + {3'h0, calm != 4'hF};
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    AST_MODE: assert property (
        s |-> extended_mode == pin_is_float[3]) else $error("mode wrong");
    AST_IDLE: assert property (
        m |-> ser == 3'h1) else $error("serial pins not idle");
    AST_RANGE: assert property (
        m |-> input_range_870 == pin_is_high[3]) else $error("range wrong");
    AST_SWING: assert property (
        m && !pin_is_float[0] |-> output_swing_700 == pin_is_high[0])
        else $error("swing wrong");
    AST_EDGE: assert property (
        m && !pin_is_float[1] |-> !output_data_clock_ddr
        && output_edge_select == pin_is_high[1]) else $error("edge wrong");
    AST_DDR: assert property (
        m && pin_is_float[1] |-> output_data_clock_ddr) else $error("no ddr");
    AST_CAL: assert property (
        m && !pin_is_float[2] |-> !dual_edge_sampling
        && calibration_delay_select == pin_is_high[2]) else $error("cal bad");
    AST_DES: assert property (
        m && pin_is_float[2] |-> dual_edge_sampling
        && !calibration_delay_select) else $error("des wrong");
    AST_SER: assert property (
        s && pin_is_float[3] |-> ser == {pin_is_high[0], pin_is_high[1],
        pin_is_high[2]}) else $error("serial routing wrong");
    AST_HOLD: assert property (
        extended_mode && $past(extended_mode) |-> $stable(cfg))
        else $error("settings moved in extended mode");
    AST_READY: assert property (
        setup_s |=> pready ##1 !pready) else $error("pready timing");
    AST_SLVERR: assert property (
        setup_s |=> pready && pslverr == $past(bad))
        else $error("pslverr wrong");
endmodule : cmpd_decoder_sva
bind cmpd_decoder cmpd_decoder_sva u_sva (
    .pclk, .presetn, .pin_is_high, .pin_is_float, .extended_mode,
    .input_range_870, .output_swing_700, .output_edge_select,
    .output_data_clock_ddr, .dual_edge_sampling, .calibration_delay_select,
    .serial_interface_clock, .serial_interface_data,
    .serial_interface_select, .psel, .penable, .pready, .pslverr, .paddr);

// file: tb/cmpd_decoder_tb.sv
// Self-checking bench for the control mode pin decoder.
`timescale 1ns/1ps
module cmpd_decoder_tb;
    localparam logic [1:0] FL = cmpd_pkg::CMPD_LVL_FLOAT;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0]  lvl;
    logic [3:0]  pin_is_high, pin_is_float;
    logic        extended_mode, input_range_870, output_swing_700;
    logic        output_edge_select, output_data_clock_ddr;
    logic        calibration_delay_select, dual_edge_sampling;
    logic        serial_interface_clock, serial_interface_data;
    logic        serial_interface_select;
    int          fail_count = 0;
    int          total_checks = 0;
    wire  [6:0]  cfg = {dual_edge_sampling, calibration_delay_select,
                        output_data_clock_ddr, output_edge_select,
                        output_swing_700, input_range_870, extended_mode};
    wire  [2:0]  ser = {serial_interface_clock, serial_interface_data,
                        serial_interface_select};

    cmpd_pin_strap u_strap (.pclk, .lvl, .pin_is_high, .pin_is_float);
    cmpd_decoder DUT (.pclk, .presetn, .pin_is_high, .pin_is_float,
        .extended_mode, .input_range_870, .output_swing_700,
        .output_edge_select, .output_data_clock_ddr,
        .calibration_delay_select, .dual_edge_sampling,
        .serial_interface_clock, .serial_interface_data,
        .serial_interface_select, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr);

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Holds the request until pready is sampled high at an edge.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic last,
                       output logic [31:0] rd, output logic er);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No wait-state limit here: the watchdog ends a hung access.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        if (last) begin
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    // Extended mode keeps the previous settings and only sets its flag.
    function automatic logic [6:0] exp_cfg(input logic [7:0] l,
                                           input logic [6:0] p);
        if (l[7:6] == FL) return {p[6:1], 1'b1};
        return {l[5:4] == FL, l[5:4] == 2'h1, l[3:2] == FL, l[3:2] == 2'h1,
                l[0], l[6], 1'b0};
    endfunction : exp_cfg

    task automatic conclude();
        if (fail_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude

    initial begin
        logic [31:0] rd;
        logic        er;
        logic [6:0]  ec;
        logic [6:0]  mk;
        logic [7:0]  l;
        integer      sd;
        sd = 32'hcb5f9ba6;
        ec = 7'h00;
        mk = 7'h7F;
        {presetn, psel, penable, pwrite, paddr, pwdata, lvl} = '0;
        repeat (2) @(posedge pclk);
        chk({cfg, ser, pready, pslverr, prdata}, {10'h001, 34'h0});
        @(posedge pclk);
        presetn <= 1'b1;
        // The first 27 passes walk every edge, delay and mode level.
        for (int i = 0; i < 60; i++) begin
            l = (i < 27) ? {2'(i % 3), 2'(i / 9), 2'(i / 3 % 3), 2'h0}
                         : 8'($random(sd));
            l[1:0] = {1'b0, 1'($random(sd))};
            for (int k = 2; k < 8; k += 2)
                if (l[k+:2] == 2'h3) l[k+:2] = FL;
            if (l[7:6] == FL) l[5:0] = l[5:0] & 6'h15;
            lvl <= l;
            ec = exp_cfg(l, ec);
            if (l[7:6] != FL) mk = (l[3:2] == FL) ? 7'h77 : 7'h7F;
            repeat (8) @(posedge pclk);
            chk(cfg & mk, ec & mk);
            chk(ser, (l[7:6] == FL) ? {l[0], l[2], l[4]} : 3'h1);
            apb(1'b0, cmpd_pkg::CMPD_OFS_STATUS, 0, 1'b1, rd, er);
            chk({er, rd & {25'h0, mk}}, {26'h0, ec & mk});
        end
        lvl <= {6'h00, FL};
        repeat (8) @(posedge pclk);
        apb(1'b0, cmpd_pkg::CMPD_OFS_CHANGE, 0, 1'b1, rd, er);
        chk(rd[1:0], 2'h3);
        lvl <= 8'h00;
        repeat (8) @(posedge pclk);
        apb(1'b1, cmpd_pkg::CMPD_OFS_CHANGE, 32'h3, 1'b0, rd, er);
        apb(1'b0, cmpd_pkg::CMPD_OFS_CHANGE, 0, 1'b0, rd, er);
        chk(rd, 32'h0);
        apb(1'b1, 12'h00C, 32'h7F, 1'b0, rd, er);
        chk(er, 1'b1);
        apb(1'b1, cmpd_pkg::CMPD_OFS_STATUS, 32'h7F, 1'b0, rd, er);
        apb(1'b0, cmpd_pkg::CMPD_OFS_STATUS, 0, 1'b0, rd, er);
        chk({er, rd}, 33'h0);
        apb(1'b0, cmpd_pkg::CMPD_OFS_PINS, 0, 1'b1, rd, er);
        chk({er, rd}, 33'h0);
        conclude();
    end

    initial begin
        #100000;
        fail_count++;
        conclude();
    end
endmodule : cmpd_decoder_tb
